// ### src/lcd_gpio_consts.svh
/*
 * Register offsets, field positions, reset values and depths
 * for the LCD-shared GPIO port block.
 * Assumes inclusion by bare name from files under src/.
 */
`ifndef LCD_GPIO_CONSTS_SVH
`define LCD_GPIO_CONSTS_SVH

// Register byte offsets on APB
`define OFS_PE_PIN 12'h000
`define OFS_PE_LAT 12'h004
`define OFS_PE_DIR 12'h008
`define OFS_PF_PIN 12'h00c
`define OFS_PF_LAT 12'h010
`define OFS_PF_DIR 12'h014
`define OFS_LCD_CTL 12'h018
`define OFS_SE_THIRD 12'h01c
`define OFS_SE_UPPER 12'h020
`define OFS_ANA_CFG 12'h024
`define OFS_PIN_SEL 12'h028

// Control, segment enable and pin select register fields
`define LCD_EN_BIT 7
`define LCD_SLP_BIT 6
`define LCD_WR_ERR_BIT 5
`define LCD_CS_HI 3
`define LCD_CS_LO 2
`define LCD_MUX_HI 1
`define LCD_MUX_LO 0
`define LCD_CTL_MASK 8'hef
`define SEG_LAST_BIT 7
`define CC2_PIN_SEL_BIT 0

// Reset values
`define RST_PE_LAT 4'h0
`define RST_PE_DIR 4'hf
`define RST_PF_LAT 8'h00
`define RST_PF_DIR 8'hff
`define RST_LCD_CTL 8'h00
`define RST_SE 8'h00
`define RST_ANA_CFG 8'h7f
`define RST_PIN_SEL 1'b1

// Synchroniser depth
`define SYNC_DEPTH 2

`endif

// ### src/lcd_gpio_pkg.sv
/*
 * Types shared by the LCD-shared GPIO port block.
 * Assumes a 12-bit APB address and 32-bit data.
 */
package lcd_gpio_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

  typedef struct packed {
    logic [1:0] clock_select;
    logic [1:0] mux_select;
    logic module_enable;
    logic sleep_enable;
  } lcd_cfg_s;

endpackage

// ### src/pin_sync.sv
/*
 * Two-flop synchroniser, one chain per bit.
 * Assumes asynchronous inputs and one destination clock.
 */
module pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  if (WIDTH < 1) begin : g_chk
    $error("pin_sync needs WIDTH of at least 1");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_ff;
    logic stab_ff;
    always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
        meta_ff <= 1'b0;
        stab_ff <= 1'b0;
      end else begin
        meta_ff <= async_i[i];
        stab_ff <= meta_ff;
      end
    end
    assign sync_o[i] = stab_ff;
  end

endmodule

// ### src/lcd_shared_gpio_ports.sv
/*
 * Two GPIO ports sharing pins with LCD drives, the second
 * capture/compare unit and analog inputs, behind an APB slave.
 * Assumes pad cells resolve the wire from out and active-low enable,
 * and that compare data comes from logic on the same clock.
 */
// The APB register port and the register offsets were chosen for this implementation.
`include "lcd_gpio_consts.svh"

// Function
// - Upper port: direction 0 drives latch bit, 1 makes Schmitt input.
// - Upper bits 4,5 and 6,7 lose digital output while LCD drives them.
// - Capture select 0: bit 7 carries compare output, or feeds capture input.
// - LCD ownership of a pin overrides its direction bit.
// - First port bits 3 to 0 unimplemented, read zero.
// - Second port 8 bits; direction 1 tristates, 0 drives latch.
// - Second port latch addressable; read-modify-write uses latch value.
// - After reset second port bits 6 to 0 are inputs reading 0.
// - Second port pins shared with segments; I/O only when segment disabled.
// - Upper bit 7 is segment 31, enabled by upper segment bit 7.
// - LCD control field layout; bit 4 unused.
// - Commons multiplex select frees upper bits 6..4, 6..5, 6 or none.
module lcd_shared_gpio_ports #(
  parameter int unsigned PF_WIDTH = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // APB slave
  input wire lcd_gpio_pkg::apb_req_s apb_req_i,
  output lcd_gpio_pkg::apb_rsp_s apb_rsp_o,
  // Upper port pads, bits 7:4
  input wire logic [3:0] pe_pad_i,
  output logic [3:0] pe_pad_o,
  output logic [3:0] pe_pad_oe_n_o,
  // Second port pads
  input wire logic [7:0] pf_pad_i,
  output logic [7:0] pf_pad_o,
  output logic [7:0] pf_pad_oe_n_o,
  // Capture/compare unit 2
  input wire logic cc2_compare_i,
  output logic cc2_capture_o,
  // LCD module side
  input wire logic lcd_write_error_i,
  output lcd_gpio_pkg::lcd_cfg_s lcd_cfg_o
);
  import lcd_gpio_pkg::*;

  if (PF_WIDTH != 8) begin : g_chk
    $error("second port is fixed at 8 bits");
  end

  // Register state
  logic [3:0] pe_lat_ff;
  logic [3:0] pe_dir_ff;
  logic [7:0] pf_lat_ff;
  logic [7:0] pf_dir_ff;
  logic [7:0] lcd_control_ff;
  logic [7:0] se_third_ff;
  logic [7:0] se_upper_ff;
  logic [7:0] analog_port_config_ff;
  logic pin_sel_ff;
  logic [31:0] prdata_ff;
  logic [3:0] pe_pad_ff;
  logic [3:0] pe_oe_n_ff;
  logic [7:0] pf_pad_ff;
  logic [7:0] pf_oe_n_ff;
  logic cc2_capture_ff;

  // Synchronised pins
  logic [3:0] pe_sync;
  logic [7:0] pf_sync;

  pin_sync #(.WIDTH(4)) u_pe_sync (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .async_i(pe_pad_i),
    .sync_o(pe_sync)
  );

  pin_sync #(.WIDTH(8)) u_pf_sync (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .async_i(pf_pad_i),
    .sync_o(pf_sync)
  );

  // Bus decode
  wire setup = apb_req_i.psel & ~apb_req_i.penable;
  wire access = apb_req_i.psel & apb_req_i.penable;
  wire [11:0] addr = apb_req_i.paddr;
  wire [7:0] wdata = apb_req_i.pwdata[7:0];
  wire hit_pe_pin = addr == `OFS_PE_PIN;
  wire hit_pe_lat = addr == `OFS_PE_LAT;
  wire hit_pe_dir = addr == `OFS_PE_DIR;
  wire hit_pf_pin = addr == `OFS_PF_PIN;
  wire hit_pf_lat = addr == `OFS_PF_LAT;
  wire hit_pf_dir = addr == `OFS_PF_DIR;
  wire hit_lcd = addr == `OFS_LCD_CTL;
  wire hit_se3 = addr == `OFS_SE_THIRD;
  wire hit_se4 = addr == `OFS_SE_UPPER;
  wire hit_ana = addr == `OFS_ANA_CFG;
  wire hit_sel = addr == `OFS_PIN_SEL;
  wire hit_any = hit_pe_pin | hit_pe_lat | hit_pe_dir | hit_pf_pin
    | hit_pf_lat | hit_pf_dir | hit_lcd | hit_se3 | hit_se4
    | hit_ana | hit_sel;
  wire wr = access & apb_req_i.pwrite & hit_any;

  // Latch writes, pin register alias included
  wire wr_pe_lat = wr & (hit_pe_pin | hit_pe_lat);
  wire wr_pf_lat = wr & (hit_pf_pin | hit_pf_lat);

  // LCD control fields
  wire lcd_en = lcd_control_ff[`LCD_EN_BIT];
  wire [1:0] mux_sel = lcd_control_ff[`LCD_MUX_HI:`LCD_MUX_LO];

  // Pin ownership by LCD
  wire [3:0] pe_own;
  assign pe_own[0] = lcd_en & (mux_sel != 2'h0);
  assign pe_own[1] = lcd_en & mux_sel[1];
  assign pe_own[2] = lcd_en & (mux_sel == 2'h3);
  assign pe_own[3] = se_upper_ff[`SEG_LAST_BIT];
  wire [7:0] pf_own = {se_upper_ff[1:0], se_third_ff[7:2]};

  // Alternate compare/capture routing on bit 7
  wire ccp_alt = ~pin_sel_ff;
  wire ccp_drive = ccp_alt & ~pe_dir_ff[3];

  // Pad next values; ownership masks direction
  wire [3:0] nxt_pe_oe_n = pe_dir_ff | pe_own;
  wire [3:0] nxt_pe_pad = {ccp_drive ? cc2_compare_i : pe_lat_ff[3],
    pe_lat_ff[2:0]};
  wire [7:0] nxt_pf_oe_n = pf_dir_ff | pf_own;
  wire nxt_cc2_capture = ccp_alt & pe_dir_ff[3] & pe_sync[3];

  // Read data
  wire [7:0] pe_pin_rd = {pe_sync, 4'h0};
  wire [7:0] pf_pin_rd = pf_sync & ~analog_port_config_ff;
  wire [7:0] lcd_rd = lcd_control_ff & `LCD_CTL_MASK;
  wire [7:0] rd_byte =
    hit_pe_pin ? pe_pin_rd :
    hit_pe_lat ? {pe_lat_ff, 4'h0} :
    hit_pe_dir ? {pe_dir_ff, 4'h0} :
    hit_pf_pin ? pf_pin_rd :
    hit_pf_lat ? pf_lat_ff :
    hit_pf_dir ? pf_dir_ff :
    hit_lcd ? lcd_rd :
    hit_se3 ? se_third_ff :
    hit_se4 ? se_upper_ff :
    hit_ana ? analog_port_config_ff :
    hit_sel ? {7'h00, pin_sel_ff} : 8'h00;
  wire [31:0] nxt_prdata = setup ? {24'h000000, rd_byte} : prdata_ff;

  // Write error flag: hardware set wins over software write
  wire nxt_wr_err = lcd_write_error_i ? 1'b1 :
    (wr & hit_lcd) ? wdata[`LCD_WR_ERR_BIT] : lcd_control_ff[`LCD_WR_ERR_BIT];
  wire [7:0] lcd_wr_val = (wr & hit_lcd) ? (wdata & `LCD_CTL_MASK) : lcd_control_ff;
  wire [7:0] nxt_lcd_ctl = {lcd_wr_val[7:6], nxt_wr_err, 1'b0,
    lcd_wr_val[3:0]};

  // Registers
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pe_lat_ff <= `RST_PE_LAT;
      pe_dir_ff <= `RST_PE_DIR;
      pf_lat_ff <= `RST_PF_LAT;
      pf_dir_ff <= `RST_PF_DIR;
      lcd_control_ff <= `RST_LCD_CTL;
      se_third_ff <= `RST_SE;
      se_upper_ff <= `RST_SE;
      analog_port_config_ff <= `RST_ANA_CFG;
      pin_sel_ff <= `RST_PIN_SEL;
    end else begin
      if (wr_pe_lat) pe_lat_ff <= wdata[7:4];
      if (wr & hit_pe_dir) pe_dir_ff <= wdata[7:4];
      if (wr_pf_lat) pf_lat_ff <= wdata;
      if (wr & hit_pf_dir) pf_dir_ff <= wdata;
      lcd_control_ff <= nxt_lcd_ctl;
      if (wr & hit_se3) se_third_ff <= wdata;
      if (wr & hit_se4) se_upper_ff <= wdata;
      if (wr & hit_ana) analog_port_config_ff <= wdata;
      if (wr & hit_sel) pin_sel_ff <= wdata[`CC2_PIN_SEL_BIT];
    end
  end

  // Pads, capture and read data
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pe_pad_ff <= 4'h0;
      pe_oe_n_ff <= 4'hf;
      pf_pad_ff <= 8'h00;
      pf_oe_n_ff <= 8'hff;
      cc2_capture_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pe_pad_ff <= nxt_pe_pad;
      pe_oe_n_ff <= nxt_pe_oe_n;
      pf_pad_ff <= pf_lat_ff;
      pf_oe_n_ff <= nxt_pf_oe_n;
      cc2_capture_ff <= nxt_cc2_capture;
      prdata_ff <= nxt_prdata;
    end
  end

  // Outputs
  assign pe_pad_o = pe_pad_ff;
  assign pe_pad_oe_n_o = pe_oe_n_ff;
  assign pf_pad_o = pf_pad_ff;
  assign pf_pad_oe_n_o = pf_oe_n_ff;
  assign cc2_capture_o = cc2_capture_ff;
  assign apb_rsp_o.pready = access;
  assign apb_rsp_o.pslverr = access & ~hit_any;
  assign apb_rsp_o.prdata = prdata_ff;
  assign lcd_cfg_o.module_enable = lcd_en;
  assign lcd_cfg_o.sleep_enable = lcd_control_ff[`LCD_SLP_BIT];
  assign lcd_cfg_o.clock_select = lcd_control_ff[`LCD_CS_HI:`LCD_CS_LO];
  assign lcd_cfg_o.mux_select = mux_sel;

  // Checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  sequence rd_setup(logic [11:0] a);
    setup && !apb_req_i.pwrite && addr == a;
  endsequence

  sequence wr_access(logic [11:0] a);
    access && apb_req_i.pwrite && addr == a;
  endsequence

  property pin_follows(logic own, logic dir, logic oe_n);
    (!own && !dir) |=> !oe_n;
  endproperty

  pe_drive_a: assert property (
    (!pe_own[1] && !pe_dir_ff[1]) |=> (!pe_pad_oe_n_o[1]
      && pe_pad_o[1] == $past(pe_lat_ff[1])))
    else $error("upper port bit 5 not driven from latch");

  pe_input_a: assert property (
    pe_dir_ff[0] |=> pe_pad_oe_n_o[0])
    else $error("upper port input bit still driven");

  com_block_a: assert property (
    (lcd_en && mux_sel == 2'h3) |=> (pe_pad_oe_n_o[2:0] == 3'h7))
    else $error("commons pins driven while LCD owns them");

  mux_free_a: assert property (
    (lcd_en && mux_sel == 2'h1 && pe_dir_ff[2:1] == 2'h0)
      |=> (pe_pad_oe_n_o[2:0] == 3'h1))
    else $error("multiplex select frees wrong pins");

  ccp_override_a: assert property (
    (!pin_sel_ff && !pe_dir_ff[3] && !pe_own[3])
      |=> (!pe_pad_oe_n_o[3] && pe_pad_o[3] == $past(cc2_compare_i)))
    else $error("compare output not on bit 7");

  ccp_capture_a: assert property (
    (!pin_sel_ff && pe_dir_ff[3]) ##1 (!pin_sel_ff && pe_dir_ff[3])
      |-> cc2_capture_o == $past(pe_sync[3], 1))
    else $error("capture input not fed from bit 7");

  lcd_override_a: assert property (
    se_upper_ff[`SEG_LAST_BIT] |=> pe_pad_oe_n_o[3])
    else $error("segment 31 pin driven digitally");

  low_nibble_a: assert property (
    (rd_setup(`OFS_PE_PIN) or rd_setup(`OFS_PE_LAT)
      or rd_setup(`OFS_PE_DIR)) |=> apb_rsp_o.prdata[3:0] == 4'h0)
    else $error("upper port low bits read nonzero");

  pf_drive_a: assert property (
    pin_follows(pf_own[4], pf_dir_ff[4], pf_pad_oe_n_o[4]))
    else $error("second port output not enabled");

  pf_tristate_a: assert property (
    pf_dir_ff[0] |=> pf_pad_oe_n_o[0])
    else $error("second port input still driven");

  latch_rmw_a: assert property (
    wr_access(`OFS_PF_LAT) ##1 rd_setup(`OFS_PF_LAT)
      |=> apb_rsp_o.prdata[7:0] == $past(apb_req_i.pwdata[7:0], 2))
    else $error("second port latch readback differs");

  analog_zero_a: assert property (
    rd_setup(`OFS_PF_PIN)
      |=> (apb_rsp_o.prdata[7:0] & $past(analog_port_config_ff)) == 8'h00)
    else $error("analog pin read nonzero");

  seg_share_a: assert property (
    se_third_ff[2] |=> pf_pad_oe_n_o[0])
    else $error("segment pin driven digitally");

  ctl_unused_a: assert property (
    rd_setup(`OFS_LCD_CTL) |=> apb_rsp_o.prdata[4] == 1'b0)
    else $error("control bit 4 reads nonzero");

  pin_alias_a: assert property (
    wr_access(`OFS_PE_PIN) |=> pe_lat_ff == $past(apb_req_i.pwdata[7:4]))
    else $error("pin register write missed latch");

  err_set_wins_a: assert property (
    lcd_write_error_i |=> lcd_control_ff[`LCD_WR_ERR_BIT])
    else $error("write error set lost");

  err_sw_write_a: assert property (
    (wr && hit_lcd && !lcd_write_error_i)
      |=> lcd_control_ff[`LCD_WR_ERR_BIT] == $past(wdata[`LCD_WR_ERR_BIT]))
    else $error("write error flag ignored software write");

  pf_latch_out_a: assert property (
    (!pf_own[7] && !pf_dir_ff[7])
      |=> (!pf_pad_oe_n_o[7] && pf_pad_o[7] == $past(pf_lat_ff[7])))
    else $error("second port bit 7 not driven from latch");

  upper_seg_a: assert property (
    se_upper_ff[1] |=> pf_pad_oe_n_o[7])
    else $error("upper segment pin driven digitally");

  seg_bit5_a: assert property (
    se_third_ff[7] |=> pf_pad_oe_n_o[5])
    else $error("third segment pin driven digitally");

  com_bit5_a: assert property (
    (lcd_en && mux_sel[1]) |=> pe_pad_oe_n_o[1])
    else $error("common pin bit 5 driven");

  lcd_off_free_a: assert property (
    (!lcd_en && !se_upper_ff[`SEG_LAST_BIT] && pe_dir_ff == 4'h0)
      |=> pe_pad_oe_n_o == 4'h0)
    else $error("upper port not driven while LCD is off");

  pe_pin_read_a: assert property (
    rd_setup(`OFS_PE_PIN) |=> apb_rsp_o.prdata[7:4] == $past(pe_sync))
    else $error("upper port pin read differs from pins");

  pf_lat_read_a: assert property (
    rd_setup(`OFS_PF_LAT) |=> apb_rsp_o.prdata[7:0] == $past(pf_lat_ff))
    else $error("second port latch read differs");

  capture_off_a: assert property (
    pin_sel_ff |=> !cc2_capture_o)
    else $error("capture fed while pin select is default");

endmodule

// ### bench/pad_model.sv
/*
 * Pad model for one port: a pin shows the block's level while
 * driven, else the level of whatever stands outside.
 * Assumes the bench sets the outside level of released pins.
 */
module pad_model #(
  parameter int unsigned W = 8
) (
  // Block pad side
  input wire logic [W-1:0] drv_i,
  input wire logic [W-1:0] oe_n_i,
  // Outside level
  input wire logic [W-1:0] ext_i,
  output logic [W-1:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released pins never keep the last driven level
  assign pin_o = (drv_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule

// ### bench/lcd_shared_gpio_ports_tb.sv
/*
 * Self-checking bench for the LCD-shared GPIO ports.
 * Assumes the pad model, the package and the consts header.
 */
`include "lcd_gpio_consts.svh"
module lcd_shared_gpio_ports_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lcd_gpio_pkg::*;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  apb_req_s req = '0;
  apb_rsp_s rsp;
  logic [3:0] pe_i, pe_o, pe_oe_n;
  logic [3:0] pe_ext = 4'h0;
  logic [7:0] pf_i, pf_o, pf_oe_n;
  logic [7:0] pf_ext = 8'h00;
  logic cmp = 1'b0;
  logic hw_err = 1'b0;
  logic cap;
  lcd_cfg_s cfg;
  int failures = 0;
  int num_checks = 0;
  logic [31:0] rd;
  logic er;
  localparam int N = 8;
  logic [11:0] ra [N] = '{`OFS_PE_LAT, `OFS_PE_DIR, `OFS_PF_LAT, `OFS_PF_DIR,
    `OFS_LCD_CTL, `OFS_SE_UPPER, `OFS_SE_THIRD, 12'h0fc};
  logic [31:0] rw [N] = '{32'hff, 32'h05, 32'h5a, 32'h3c, 32'hff, 32'h81, 32'h42, 32'h01};
  logic [31:0] rx [N] = '{32'hf0, 32'h00, 32'h5a, 32'h3c, 32'hef, 32'h81, 32'h42, 32'h00};
  logic re [N] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

  lcd_shared_gpio_ports u_dut (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .apb_req_i(req),
    .apb_rsp_o(rsp),
    .pe_pad_i(pe_i),
    .pe_pad_o(pe_o),
    .pe_pad_oe_n_o(pe_oe_n),
    .pf_pad_i(pf_i),
    .pf_pad_o(pf_o),
    .pf_pad_oe_n_o(pf_oe_n),
    .cc2_compare_i(cmp),
    .cc2_capture_o(cap),
    .lcd_write_error_i(hw_err),
    .lcd_cfg_o(cfg)
  );
  pad_model #(.W(4)) u_pe (.drv_i(pe_o), .oe_n_i(pe_oe_n), .ext_i(pe_ext), .pin_o(pe_i));
  pad_model #(.W(8)) u_pf (.drv_i(pf_o), .oe_n_i(pf_oe_n), .ext_i(pf_ext), .pin_o(pf_i));

  initial begin
    forever #12.5 clock_i = ~clock_i;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i) req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock_i) req.penable <= 1'b1;
    do @(posedge clock_i); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task wr_then_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
    @(posedge clock_i) req <= '{1'b1, 1'b0, 1'b1, a, d};
    @(posedge clock_i) req.penable <= 1'b1;
    do @(posedge clock_i); while (rsp.pready !== 1'b1);
    req <= '{1'b1, 1'b0, 1'b0, a, 32'h0};
    @(posedge clock_i) req.penable <= 1'b1;
    do @(posedge clock_i); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    chk(rd, exp);
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #(25 * 5000);
    failures++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge clock_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < N; i++) begin
      wr(ra[i], rw[i]);
      chk({31'h0, er}, {31'h0, re[i]});
      rdc(ra[i], rx[i]);
    end
    chk(cfg, 32'h3f);
    // Second port as digital I/O
    wr(`OFS_ANA_CFG, 32'h0);
    wr(`OFS_SE_THIRD, 32'h0);
    wr(`OFS_SE_UPPER, 32'h0);
    wr(`OFS_PF_DIR, 32'h0);
    wr(`OFS_PF_LAT, 32'ha5);
    cyc(2);
    chk(pf_oe_n, 32'h0);
    chk(pf_o, 32'ha5);
    cyc(3);
    rdc(`OFS_PF_PIN, 32'ha5);
    wr(`OFS_PF_PIN, 32'h3c);
    rdc(`OFS_PF_LAT, 32'h3c);
    wr_then_rd(`OFS_PF_LAT, 32'h6c, 32'h6c);
    @(posedge clock_i) pf_ext <= 8'h96;
    wr(`OFS_PF_DIR, 32'hf0);
    cyc(4);
    rdc(`OFS_PF_PIN, 32'h9c);
    // Segments own second-port pins
    wr(`OFS_PF_DIR, 32'h0);
    wr(`OFS_SE_THIRD, 32'hfc);
    wr(`OFS_SE_UPPER, 32'h03);
    cyc(2);
    chk(pf_oe_n, 32'hff);
    // Commons take upper-port pins
    wr(`OFS_SE_UPPER, 32'h0);
    wr(`OFS_PE_DIR, 32'h0);
    wr(`OFS_PE_LAT, 32'h00);
    wr(`OFS_PE_PIN, 32'hf0);
    rdc(`OFS_PE_LAT, 32'hf0);
    for (int m = 0; m < 4; m++) begin
      wr(`OFS_LCD_CTL, 32'h80 | m);
      cyc(2);
      chk(pe_oe_n, {1'b0, m == 3, m[1], m != 0});
    end
    wr(`OFS_LCD_CTL, 32'h03);
    cyc(2);
    chk(pe_oe_n, 32'h0);
    chk(pe_o, 32'hf);
    wr(`OFS_SE_UPPER, 32'h80);
    cyc(2);
    chk(pe_oe_n, 32'h8);
    // Alternate compare and capture pin
    wr(`OFS_SE_UPPER, 32'h0);
    wr(`OFS_PE_LAT, 32'h0);
    wr(`OFS_PIN_SEL, 32'h0);
    @(posedge clock_i) cmp <= 1'b1;
    cyc(2);
    chk(pe_o, 32'h8);
    @(posedge clock_i) cmp <= 1'b0;
    cyc(2);
    chk(pe_o, 32'h0);
    wr(`OFS_PE_DIR, 32'h80);
    @(posedge clock_i) pe_ext <= 4'h8;
    cyc(4);
    chk({31'h0, cap}, 32'h1);
    rdc(`OFS_PE_PIN, 32'h80);
    // Hardware write error
    @(posedge clock_i) hw_err <= 1'b1;
    @(posedge clock_i) hw_err <= 1'b0;
    rdc(`OFS_LCD_CTL, 32'h23);
    wr(`OFS_LCD_CTL, 32'h03);
    rdc(`OFS_LCD_CTL, 32'h03);
    // Hardware set and software clear in one cycle
    fork
      wr(`OFS_LCD_CTL, 32'h03);
      begin
        repeat (2) @(posedge clock_i);
        hw_err <= 1'b1;
        @(posedge clock_i) hw_err <= 1'b0;
      end
    join
    rdc(`OFS_LCD_CTL, 32'h23);
    // Reset in mid-run
    @(posedge clock_i) resetn_i <= 1'b0;
    pf_ext <= 8'hff;
    cyc(3);
    @(posedge clock_i) resetn_i <= 1'b1;
    cyc(4);
    chk(pf_oe_n, 32'hff);
    chk(pe_oe_n, 32'hf);
    rdc(`OFS_PF_PIN, 32'h80);
    rdc(`OFS_PE_DIR, 32'hf0);
    rdc(`OFS_PF_DIR, 32'hff);
    rdc(`OFS_LCD_CTL, 32'h0);
    end_sim();
  end
endmodule
